/* File: verilog/tcs_pkg.sv */
// Purpose: shared constants for the timer channel status flag block
// Assumes: 32-bit classic Wishbone slave, byte addresses, one word per register
// Notes: event flag layout is identical in every channel; unused bits are masked per channel
package tcs_pkg;

  // widths
  localparam int unsigned TCS_NUM_CH = 3;
  localparam int unsigned TCS_CNT_W = 16;
  localparam int unsigned TCS_FLAG_W = 6;
  localparam int unsigned TCS_ADR_W = 8;
  localparam int unsigned TCS_NUM_GR = 8;

  // counter wrap points
  localparam logic [15:0] TCS_CNT_ZERO = 16'h0000;
  localparam logic [15:0] TCS_CNT_ONES = 16'hFFFF;

  // register byte offsets
  localparam logic [7:0] TCS_OFS_STATUS0 = 8'h00;
  localparam logic [7:0] TCS_OFS_STATUS1 = 8'h04;
  localparam logic [7:0] TCS_OFS_STATUS2 = 8'h08;
  localparam logic [7:0] TCS_OFS_IRQEN0 = 8'h0C;
  localparam logic [7:0] TCS_OFS_IRQEN1 = 8'h10;
  localparam logic [7:0] TCS_OFS_IRQEN2 = 8'h14;
  localparam logic [7:0] TCS_OFS_EVSTAT = 8'h18;
  localparam logic [7:0] TCS_OFS_EVMASK = 8'h1C;

  // status register field positions
  localparam int unsigned TCS_BIT_DIR = 7;
  localparam int unsigned TCS_BIT_RSV = 6;
  localparam int unsigned TCS_BIT_UNF = 5;
  localparam int unsigned TCS_BIT_OVF = 4;
  localparam int unsigned TCS_BIT_EVD = 3;
  localparam int unsigned TCS_BIT_EVC = 2;
  localparam int unsigned TCS_BIT_EVB = 1;
  localparam int unsigned TCS_BIT_EVA = 0;

  // which event flags exist per channel kind
  localparam logic [5:0] TCS_IMPL_CH0 = 6'h1F;
  localparam logic [5:0] TCS_IMPL_CH12 = 6'h33;

  // reset values
  localparam logic [7:0] TCS_RST_STATUS_CH0 = 8'h40;
  localparam logic [7:0] TCS_RST_STATUS_CH12 = 8'hC0;
  localparam logic [5:0] TCS_RST_IRQEN = 6'h00;
  localparam logic [2:0] TCS_RST_EV = 3'h0;

endpackage

/* File: verilog/tcs_gr_event.sv */
// Purpose: event detection for one general register (compare match or capture)
// Assumes: counter, register value, role and capture strobe are synchronous to ref_clk
// Notes: one-cycle pulse output, registered
`timescale 1ns/10ps
module tcs_gr_event (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // datapath view
  input wire logic [tcs_pkg::TCS_CNT_W-1:0] count,
  input wire logic [tcs_pkg::TCS_CNT_W-1:0] grValue,
  input wire logic roleCapture,
  input wire logic captureStb,
  // result
  output logic evt
);
  import tcs_pkg::*;

  logic wasEqual;
  wire isEqual = (count == grValue);
  // only the moment of becoming equal counts, so a stopped counter does not re-flag
  wire matchEdge = !roleCapture && isEqual && !wasEqual;
  wire capHit = roleCapture && captureStb;

  // remember equality to find the rising edge
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wasEqual <= 1'b1;
      evt <= 1'b0;
    end else begin
      wasEqual <= isEqual;
      evt <= matchEdge || capHit;
    end
  end
endmodule

/* File: verilog/tcs_chan_flags.sv */
// Purpose: status register of one timer channel
// Assumes: bus side gives one-cycle write and read-commit strobes
// Notes: a flag clears only after it was returned as 1 on a read
`timescale 1ns/10ps
module tcs_chan_flags #(
  parameter logic [5:0] IMPL = 6'h1F,
  parameter bit HAS_DIR = 1'b0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // counter view
  input wire logic [tcs_pkg::TCS_CNT_W-1:0] count,
  input wire logic countUp,
  input wire logic [3:0] grEvt,
  // bus side
  input wire logic wrEn,
  input wire logic [7:0] wrData,
  input wire logic rdEn,
  input wire logic [7:0] rdData,
  // results
  output logic [7:0] status,
  output logic anySet
);
  import tcs_pkg::*;

  logic [TCS_CNT_W-1:0] prevCount;
  logic [5:0] flag;
  logic [5:0] armed;
  logic dirUp;

  // wraps seen between two consecutive samples of the counter
  wire ovf = (prevCount == TCS_CNT_ONES) && (count == TCS_CNT_ZERO);
  wire unf = (prevCount == TCS_CNT_ZERO) && (count == TCS_CNT_ONES);
  wire [5:0] setEv = {unf, ovf, grEvt} & IMPL;
  // write of 0 clears only an armed flag; writing 1 does nothing
  wire [5:0] clr = {6{wrEn}} & ~wrData[5:0] & armed;
  wire [5:0] next_flag = IMPL & (setEv | (flag & ~clr));
  wire [5:0] next_armed = IMPL & ((armed & ~({6{wrEn}} & ~wrData[5:0])) | ({6{rdEn}} & rdData[5:0]));

  assign status = {HAS_DIR & dirUp, 1'b1, flag};
  assign anySet = |setEv;

  // flags, arming and direction
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prevCount <= TCS_CNT_ZERO;
      flag <= 6'h00;
      armed <= 6'h00;
      dirUp <= 1'b1;
    end else begin
      prevCount <= count;
      flag <= next_flag;
      armed <= next_armed;
      dirUp <= countUp;
    end
  end
endmodule

/* File: verilog/tcs_top.sv */
// Purpose: status flags of a three-channel 16-bit timer, read and cleared over Wishbone
// Assumes: counter values, register roles and capture strobes come from the timer datapath
// Notes: one status register per channel, interrupt enables, sticky event summary with mask
//
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
module tcs_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [tcs_pkg::TCS_ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // channel 0 datapath
  input wire logic [tcs_pkg::TCS_CNT_W-1:0] count0,
  input wire logic [tcs_pkg::TCS_CNT_W-1:0] grA0,
  input wire logic [tcs_pkg::TCS_CNT_W-1:0] grB0,
  input wire logic [tcs_pkg::TCS_CNT_W-1:0] grC0,
  input wire logic [tcs_pkg::TCS_CNT_W-1:0] grD0,
  input wire logic [3:0] roleCapture0,
  input wire logic [3:0] captureStb0,
  // channel 1 datapath
  input wire logic [tcs_pkg::TCS_CNT_W-1:0] count1,
  input wire logic countUp1,
  input wire logic [tcs_pkg::TCS_CNT_W-1:0] grA1,
  input wire logic [tcs_pkg::TCS_CNT_W-1:0] grB1,
  input wire logic [1:0] roleCapture1,
  input wire logic [1:0] captureStb1,
  // channel 2 datapath
  input wire logic [tcs_pkg::TCS_CNT_W-1:0] count2,
  input wire logic countUp2,
  input wire logic [tcs_pkg::TCS_CNT_W-1:0] grA2,
  input wire logic [tcs_pkg::TCS_CNT_W-1:0] grB2,
  input wire logic [1:0] roleCapture2,
  input wire logic [1:0] captureStb2,
  // interrupt requests
  output logic [5:0] chanIrq0,
  output logic [5:0] chanIrq1,
  output logic [5:0] chanIrq2,
  output logic irq
);
  import tcs_pkg::*;

  // the detectors all share one shape, so the channel datapath is flattened
  // into arrays first; channels 1 and 2 simply have two slots each
  // per-register datapath gathered into arrays, order A0 B0 C0 D0 A1 B1 A2 B2
  logic [TCS_CNT_W-1:0] grCount [TCS_NUM_GR];
  logic [TCS_CNT_W-1:0] grVal [TCS_NUM_GR];
  logic [TCS_NUM_GR-1:0] grRole;
  logic [TCS_NUM_GR-1:0] grCap;
  logic [TCS_NUM_GR-1:0] grEvt;

  assign grCount[0] = count0;
  assign grCount[1] = count0;
  assign grCount[2] = count0;
  assign grCount[3] = count0;
  assign grCount[4] = count1;
  assign grCount[5] = count1;
  assign grCount[6] = count2;
  assign grCount[7] = count2;
  assign grVal[0] = grA0;
  assign grVal[1] = grB0;
  assign grVal[2] = grC0;
  assign grVal[3] = grD0;
  assign grVal[4] = grA1;
  assign grVal[5] = grB1;
  assign grVal[6] = grA2;
  assign grVal[7] = grB2;
  // role and strobe vectors follow the same slot order as the arrays
  assign grRole = {roleCapture2, roleCapture1, roleCapture0};
  assign grCap = {captureStb2, captureStb1, captureStb0};

  // one detector per general register
  // each detector registers its pulse, so a flag shows two edges after the
  // equality or strobe; overflow and underflow show one edge after the wrap
  genvar g;
  generate
    for (g = 0; g < TCS_NUM_GR; g++) begin : gen_gr
      tcs_gr_event u_ev (
        .ref_clk(ref_clk),
        .srst(srst),
        .count(grCount[g]),
        .grValue(grVal[g]),
        .roleCapture(grRole[g]),
        .captureStb(grCap[g]),
        .evt(grEvt[g])
      );
    end
  endgenerate

  // bus decode; a write or read takes effect at the edge where ack is seen high
  // the slave answers every request, mapped or not, so a stray address cannot
  // hang the master; unmapped writes are dropped and unmapped reads give zero
  // sel_i[0] gates writes because every register lives in the low byte
  // a read commits on the same edge a write would, so arming and clearing share timing
  wire busReq = cyc_i && stb_i;
  wire busCommit = busReq && ack_o;
  wire wrCommit = busCommit && we_i && sel_i[0];
  wire rdCommit = busCommit && !we_i;
  wire hitSt0 = (adr_i == TCS_OFS_STATUS0);
  wire hitSt1 = (adr_i == TCS_OFS_STATUS1);
  wire hitSt2 = (adr_i == TCS_OFS_STATUS2);
  wire hitEn0 = (adr_i == TCS_OFS_IRQEN0);
  wire hitEn1 = (adr_i == TCS_OFS_IRQEN1);
  wire hitEn2 = (adr_i == TCS_OFS_IRQEN2);
  wire hitEvS = (adr_i == TCS_OFS_EVSTAT);
  wire hitEvM = (adr_i == TCS_OFS_EVMASK);
  wire [2:0] stWr = {3{wrCommit}} & {hitSt2, hitSt1, hitSt0};
  // arming uses the very byte that was handed to the master
  // a flag set after the read data was frozen is not armed, so software
  // can never clear an event it has not seen
  wire [2:0] stRd = {3{rdCommit}} & {hitSt2, hitSt1, hitSt0};
  wire [7:0] rdByte = dat_o[7:0];

  // three channel status registers
  // channel 0 owns all four general registers and no direction bit;
  // channels 1 and 2 own two registers, a direction bit and underflow
  // all three see the same write byte; only the addressed one acts on it
  logic [7:0] status0;
  logic [7:0] status1;
  logic [7:0] status2;
  logic [2:0] chanSet;

  tcs_chan_flags #(
    .IMPL(TCS_IMPL_CH0),
    .HAS_DIR(1'b0)
  ) u_ch0 (
    .ref_clk(ref_clk),
    .srst(srst),
    .count(count0),
    .countUp(1'b1),
    .grEvt(grEvt[3:0]),
    .wrEn(stWr[0]),
    .wrData(dat_i[7:0]),
    .rdEn(stRd[0]),
    .rdData(rdByte),
    .status(status0),
    .anySet(chanSet[0])
  );

  tcs_chan_flags #(
    .IMPL(TCS_IMPL_CH12),
    .HAS_DIR(1'b1)
  ) u_ch1 (
    .ref_clk(ref_clk),
    .srst(srst),
    .count(count1),
    .countUp(countUp1),
    .grEvt({2'b00, grEvt[5:4]}),
    .wrEn(stWr[1]),
    .wrData(dat_i[7:0]),
    .rdEn(stRd[1]),
    .rdData(rdByte),
    .status(status1),
    .anySet(chanSet[1])
  );

  tcs_chan_flags #(
    .IMPL(TCS_IMPL_CH12),
    .HAS_DIR(1'b1)
  ) u_ch2 (
    .ref_clk(ref_clk),
    .srst(srst),
    .count(count2),
    .countUp(countUp2),
    .grEvt({2'b00, grEvt[7:6]}),
    .wrEn(stWr[2]),
    .wrData(dat_i[7:0]),
    .rdEn(stRd[2]),
    .rdData(rdByte),
    .status(status2),
    .anySet(chanSet[2])
  );

  // interrupt enables per channel, same layout as the flags
  logic [5:0] irqEn0;
  logic [5:0] irqEn1;
  logic [5:0] irqEn2;
  // missing flags cannot be enabled either
  // unimplemented enable bits read back as zero, like their flags
  // writes with sel_i[0] low leave the enables untouched
  wire [5:0] next_irqEn0 = (wrCommit && hitEn0) ? (dat_i[5:0] & TCS_IMPL_CH0) : irqEn0;
  wire [5:0] next_irqEn1 = (wrCommit && hitEn1) ? (dat_i[5:0] & TCS_IMPL_CH12) : irqEn1;
  wire [5:0] next_irqEn2 = (wrCommit && hitEn2) ? (dat_i[5:0] & TCS_IMPL_CH12) : irqEn2;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irqEn0 <= TCS_RST_IRQEN;
      irqEn1 <= TCS_RST_IRQEN;
      irqEn2 <= TCS_RST_IRQEN;
    end else begin
      irqEn0 <= next_irqEn0;
      irqEn1 <= next_irqEn1;
      irqEn2 <= next_irqEn2;
    end
  end

  // sticky per-channel event summary, write one to clear, set wins
  // the summary lets one level line stand for all three channels; software
  // finds the channel here, then reads that channel's status register
  // a channel event in the same cycle as a clear keeps the bit set
  logic [2:0] evStat;
  logic [2:0] evMask;
  wire [2:0] evClr = (wrCommit && hitEvS) ? dat_i[2:0] : 3'h0;
  wire [2:0] next_evStat = chanSet | (evStat & ~evClr);
  wire [2:0] next_evMask = (wrCommit && hitEvM) ? dat_i[2:0] : evMask;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      evStat <= TCS_RST_EV;
      evMask <= TCS_RST_EV;
    end else begin
      evStat <= next_evStat;
      evMask <= next_evMask;
    end
  end

  // request lines: flag and enable, one cycle of register delay
  // each channel request follows the flag level, so it drops as soon as software
  // clears the flag or the enable; irq follows the sticky summary and the mask;
  // nothing here is edge triggered
  // registered so that every output of the block comes straight from a flop
  wire [5:0] next_chanIrq0 = status0[5:0] & irqEn0;
  wire [5:0] next_chanIrq1 = status1[5:0] & irqEn1;
  wire [5:0] next_chanIrq2 = status2[5:0] & irqEn2;
  wire next_irq = |(evStat & evMask);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      chanIrq0 <= 6'h00;
      chanIrq1 <= 6'h00;
      chanIrq2 <= 6'h00;
      irq <= 1'b0;
    end else begin
      chanIrq0 <= next_chanIrq0;
      chanIrq1 <= next_chanIrq1;
      chanIrq2 <= next_chanIrq2;
      irq <= next_irq;
    end
  end

  // read mux; unmapped addresses answer with zero
  // addresses are exclusive, so the priority order of this chain is immaterial
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h00000000;
    if (hitSt0) begin
      rdMux = {24'h000000, status0};
    end else if (hitSt1) begin
      rdMux = {24'h000000, status1};
    end else if (hitSt2) begin
      rdMux = {24'h000000, status2};
    end else if (hitEn0) begin
      rdMux = {26'h0000000, irqEn0};
    end else if (hitEn1) begin
      rdMux = {26'h0000000, irqEn1};
    end else if (hitEn2) begin
      rdMux = {26'h0000000, irqEn2};
    end else if (hitEvS) begin
      rdMux = {29'h00000000, evStat};
    end else if (hitEvM) begin
      rdMux = {29'h00000000, evMask};
    end
  end

  // ack one cycle after the request, dropped the cycle after; data frozen with ack
  // a zero-wait answer is traded away: the read data is registered so that the
  // value armed on the commit edge is exactly the value the master took
  // dat_o keeps the last answer between accesses; only ack_o qualifies it
  wire next_ack = busReq && !ack_o;
  wire [31:0] next_dat = next_ack ? rdMux : dat_o;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= next_ack;
      dat_o <= next_dat;
    end
  end
endmodule

/* File: tb/tcs_top_checker.sv */
// Purpose: port-level checks of the timer status flag block
// Assumes: bus master holds address and direction through the ack cycle
// Notes: status timing is checked only through bus reads
`timescale 1ns/10ps
module tcs_top_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // datapath and requests
  input wire logic countUp1,
  input wire logic [5:0] chanIrq0,
  input wire logic [5:0] chanIrq1,
  input wire logic [5:0] chanIrq2,
  input wire logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // a read answer with the address still held by the master
  wire logic isRd = ack_o && !we_i;
  a_ack_one_cycle: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  a_ack_has_cause: assert property (ack_o |-> $past(cyc_i && stb_i) && cyc_i) else $error("ack without request");
  a_ch0_fixed_bits: assert property (isRd && adr_i == 8'h00 |-> dat_o[7:5] == 3'b010)
    else $error("channel 0 fixed bits wrong");
  a_reserved_one: assert property (isRd && adr_i inside {8'h00, 8'h04, 8'h08} |-> dat_o[6] && dat_o[31:8] == 24'h0)
    else $error("reserved bit not one");
  a_ch12_cd_zero: assert property (isRd && adr_i inside {8'h04, 8'h08} |-> dat_o[3:2] == 2'b00)
    else $error("missing register flags set");
  // direction settles within two cycles, so ask for three stable cycles first
  a_dir_follows: assert property (isRd && adr_i == 8'h04 && !$past(srst) && !$past(srst, 2) && !$past(srst, 3)
    && $past(countUp1) == countUp1 && $past(countUp1, 2) == countUp1 && $past(countUp1, 3) == countUp1
    |-> dat_o[7] == countUp1) else $error("direction bit wrong");
  a_irq_cd_quiet: assert property (chanIrq1[3:2] == 2'b00 && chanIrq2[3:2] == 2'b00) else $error("missing irq raised");
  a_irq_ch0_unf: assert property (chanIrq0[5] == 1'b0) else $error("channel 0 underflow irq raised");
  a_reset_quiet: assert property ($past(srst) |-> !ack_o && !irq && (chanIrq0 | chanIrq1 | chanIrq2) == 6'h00)
    else $error("outputs active after reset");
  c_status1_read: cover property (isRd && adr_i == 8'h04);
  c_write_done: cover property (ack_o && we_i);
  c_irq_high: cover property (irq);
  c_unf_irq: cover property (chanIrq1[5]);
endmodule
bind tcs_top tcs_top_checker chk (.ref_clk(ref_clk), .srst(srst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .countUp1(countUp1), .chanIrq0(chanIrq0), .chanIrq1(chanIrq1),
  .chanIrq2(chanIrq2), .irq(irq));

/* File: tb/tcs_top_test.sv */
// Purpose: self-checking bench for the timer status flag block
// Assumes: wishbone answer one cycle after request, flags settle within three cycles
// Notes: counters idle at 0800, which no general register value ever equals
`timescale 1ns/10ps
module tcs_top_test;
  import tcs_pkg::*;
  // stimulus
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [3:0] selVal = 4'hF;
  logic [31:0] dat_i = 32'h0;
  logic [15:0] cnt [3];
  logic [15:0] gr [3][4];
  logic [3:0] role [3];
  logic [3:0] stb [3];
  logic [2:0] dir = 3'h6;
  // observed
  logic [31:0] dat_o;
  logic ack_o, irq;
  logic [5:0] chanIrq0, chanIrq1, chanIrq2;
  // expected flags and bookkeeping
  logic [5:0] flg [3];
  logic [31:0] q;
  integer seed = 32'hD4147200;
  int numErrors = 0;
  int nCompared = 0;

  always #2.5 ref_clk = ~ref_clk;

  tcs_top uut (.ref_clk(ref_clk), .srst(srst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .count0(cnt[0]), .grA0(gr[0][0]),
    .grB0(gr[0][1]), .grC0(gr[0][2]), .grD0(gr[0][3]), .roleCapture0(role[0]), .captureStb0(stb[0]),
    .count1(cnt[1]), .countUp1(dir[1]), .grA1(gr[1][0]), .grB1(gr[1][1]), .roleCapture1(role[1][1:0]),
    .captureStb1(stb[1][1:0]), .count2(cnt[2]), .countUp2(dir[2]), .grA2(gr[2][0]), .grB2(gr[2][1]),
    .roleCapture2(role[2][1:0]), .captureStb2(stb[2][1:0]), .chanIrq0(chanIrq0), .chanIrq1(chanIrq1),
    .chanIrq2(chanIrq2), .irq(irq));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    nCompared++;
    if (g !== e) begin
      numErrors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one classic cycle; waits for ack under a bound
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= selVal;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    chk("ack", 32'h1, {31'h0, ack_o});
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    sel_i <= 4'h0;
    @(posedge ref_clk);
  endtask

  function automatic logic [7:0] expStat(input int ch);
    return {((ch == 0) ? 1'b0 : dir[ch]), 1'b1, flg[ch] & ((ch == 0) ? TCS_IMPL_CH0 : TCS_IMPL_CH12)};
  endfunction

  task automatic rdChk(input int ch);
    logic [31:0] r;
    wb(1'b0, 8'(ch * 4), 32'h0, r);
    chk("status", {24'h0, expStat(ch)}, r);
  endtask

  task automatic checkAll();
    for (int c = 0; c < 3; c++) rdChk(c);
  endtask

  // read arms, writing zero clears
  task automatic clearAll();
    logic [31:0] r;
    for (int c = 0; c < 3; c++) begin
      wb(1'b0, 8'(c * 4), 32'h0, r);
      wb(1'b1, 8'(c * 4), 32'h0, r);
      flg[c] = 6'h00;
    end
  endtask

  // raise flag k of channel ch; a counter wrap for k 4 and 5, otherwise capture or compare chosen at random
  task automatic ev(input int ch, input int k);
    logic [15:0] r;
    r = {4'(ch + 1), 4'(k), 8'($random(seed))};
    if (k == 4) begin
      cnt[ch] <= 16'hFFFF;
      @(posedge ref_clk);
      cnt[ch] <= 16'h0000;
    end else if (k == 5) begin
      cnt[ch] <= 16'h0000;
      @(posedge ref_clk);
      cnt[ch] <= 16'hFFFF;
    end else if ($random(seed) & 1) begin
      role[ch][k] <= 1'b1;
      @(posedge ref_clk);
      stb[ch][k] <= 1'b1;
      @(posedge ref_clk);
      stb[ch][k] <= 1'b0;
    end else begin
      role[ch][k] <= 1'b0;
      gr[ch][k] <= r;
      @(posedge ref_clk);
      cnt[ch] <= r;
    end
    @(posedge ref_clk);
    cnt[ch] <= 16'h0800;
    repeat (3) @(posedge ref_clk);
    flg[ch] = flg[ch] | (6'h01 << k);
  endtask

  task automatic endSim();
    $display("compared %0d mismatches %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // watchdog, far beyond the roughly 500 cycles the tests need
  initial begin
    repeat (40000) @(posedge ref_clk);
    numErrors++;
    $display("MISMATCH watchdog expected done seen timeout");
    endSim();
  end

  initial begin
    for (int c = 0; c < 3; c++) begin
      cnt[c] = 16'h0800;
      role[c] = 4'h0;
      stb[c] = 4'h0;
      flg[c] = 6'h00;
      for (int k = 0; k < 4; k++) gr[c][k] = {4'(c + 1), 4'(k), 8'h00};
    end
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    checkAll();
    wb(1'b0, 8'h20, 32'h0, q);
    chk("unmapped", 32'h0, q);
    $display("test reset done");
    // every flag position on every channel, missing ones must stay zero
    for (int c = 0; c < 3; c++) begin
      for (int k = 0; k < 6; k++) begin
        ev(c, k);
        checkAll();
      end
      clearAll();
      checkAll();
    end
    $display("test flags done");
    dir[2:1] <= 2'b00;
    repeat (4) @(posedge ref_clk);
    rdChk(1);
    rdChk(2);
    dir[2:1] <= 2'b11;
    repeat (4) @(posedge ref_clk);
    rdChk(1);
    rdChk(2);
    $display("test direction done");
    // zero without a prior read, then ones, then a proper clear
    ev(1, 0);
    wb(1'b1, 8'h04, 32'h0, q);
    rdChk(1);
    wb(1'b1, 8'h04, 32'hFF, q);
    rdChk(1);
    wb(1'b1, 8'h04, 32'h0, q);
    flg[1] = 6'h00;
    rdChk(1);
    // a clear that meets a new overflow on the same edge must lose
    ev(2, 4);
    rdChk(2);
    fork
      wb(1'b1, TCS_OFS_STATUS2, 32'h0, q);
      begin
        cnt[2] <= 16'hFFFF;
        @(posedge ref_clk);
        cnt[2] <= 16'h0000;
        @(posedge ref_clk);
        cnt[2] <= 16'h0800;
      end
    join
    rdChk(2);
    wb(1'b1, TCS_OFS_STATUS2, 32'h0, q);
    flg[2] = 6'h00;
    rdChk(2);
    $display("test clear done");
    wb(1'b1, TCS_OFS_EVSTAT, 32'h7, q);
    ev(0, 4);
    wb(1'b1, TCS_OFS_IRQEN0, 32'h3F, q);
    repeat (3) @(posedge ref_clk);
    chk("chanIrq0", {26'h0, flg[0]}, {26'h0, chanIrq0});
    wb(1'b0, TCS_OFS_EVSTAT, 32'h0, q);
    chk("evstat", 32'h1, q);
    wb(1'b1, TCS_OFS_EVMASK, 32'h1, q);
    repeat (3) @(posedge ref_clk);
    chk("irq", 32'h1, {31'h0, irq});
    wb(1'b1, TCS_OFS_EVSTAT, 32'h1, q);
    wb(1'b1, TCS_OFS_IRQEN0, 32'h0, q);
    repeat (3) @(posedge ref_clk);
    chk("irq", 32'h0, {31'h0, irq});
    chk("chanIrq0", 32'h0, {26'h0, chanIrq0});
    // a write with the low byte lane off must leave the enable alone
    selVal = 4'hE;
    wb(1'b1, TCS_OFS_IRQEN1, 32'h3F, q);
    selVal = 4'hF;
    wb(1'b0, TCS_OFS_IRQEN1, 32'h0, q);
    chk("irqen1 lane off", 32'h0, q);
    ev(1, 5);
    ev(2, 1);
    wb(1'b1, TCS_OFS_IRQEN1, 32'h3F, q);
    wb(1'b1, TCS_OFS_IRQEN2, 32'h3F, q);
    wb(1'b0, TCS_OFS_IRQEN2, 32'h0, q);
    chk("irqen2", {26'h0, TCS_IMPL_CH12}, q);
    wb(1'b1, TCS_OFS_EVMASK, 32'h6, q);
    repeat (3) @(posedge ref_clk);
    chk("chanIrq1", {26'h0, flg[1]}, {26'h0, chanIrq1});
    chk("chanIrq2", {26'h0, flg[2]}, {26'h0, chanIrq2});
    chk("irq", 32'h1, {31'h0, irq});
    wb(1'b1, TCS_OFS_IRQEN1, 32'h0, q);
    wb(1'b1, TCS_OFS_IRQEN2, 32'h0, q);
    wb(1'b1, TCS_OFS_EVSTAT, 32'h6, q);
    repeat (3) @(posedge ref_clk);
    chk("chanIrq1", 32'h0, {26'h0, chanIrq1});
    chk("chanIrq2", 32'h0, {26'h0, chanIrq2});
    chk("irq", 32'h0, {31'h0, irq});
    $display("test interrupt done");
    // a second reset in mid-run must bring back the reset view
    ev(0, 0);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    for (int c = 0; c < 3; c++) flg[c] = 6'h00;
    checkAll();
    chk("irq after reset", 32'h0, {31'h0, irq});
    $display("test second reset done");
    endSim();
  end
endmodule
